// [slfs_analog_model.sv]
// Supply comparator bank that faces the supervisor.
// Assumes the bench sets the supply in millivolts off the clock edge.
`timescale 1ns/1ps
module slfs_analog_model #(
    parameter int ON_MV    = 12500,
    parameter int MIN_MV   = 6600,
    parameter int WAKE_MV  = 7600,
    parameter int BURST_MV = 8100,
    parameter int MAX_MV   = 25000
) (
    input  wire integer vcc_mv,
    output logic      above_on,
    output logic      below_min,
    output logic      below_wake,
    output logic      above_burst,
    output logic      above_max
);
    // ------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------
    // Ideal levels, no noise: hysteresis lives in the supervisor
    assign above_on    = vcc_mv > ON_MV;
    assign below_min   = vcc_mv < MIN_MV;
    assign below_wake  = vcc_mv <= WAKE_MV;
    assign above_burst = vcc_mv >= BURST_MV;
    assign above_max   = vcc_mv > MAX_MV;
endmodule // slfs_analog_model

// [slfs_blank.sv]
// Blanking qualifier for one fault comparator.
// Assumes a synchronous comparator input and a state enable.
`timescale 1ns/1ps
`include "slfs_defs.svh"
module slfs_blank #(
    parameter int N = 4
) (
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic en,
    input  wire logic cmp,
    output logic      fault
);
    logic [`SLFS_CNT_W-1:0] cnt_r;
    logic [`SLFS_CNT_W-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (!(cmp && en)) begin
            cnt_nxt = '0;
        end else if (cnt_r != N[`SLFS_CNT_W-1:0]) begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Counter restarts on any drop of the comparator
    assign fault = en && cmp && (cnt_r == N[`SLFS_CNT_W-1:0]);

    a_blank_time: assert property (@(posedge sys_clk) disable iff (!arst_n)
        fault |-> $past(cmp && en)) else $error("fault without qualified comparator");
endmodule // slfs_blank

// [slfs_defs.svh]
// Constants for the supply lockout and fault supervisor.
// Assumes a 250 MHz sys_clk; times are kept in ns and converted to cycles.
`ifndef SLFS_DEFS_SVH
`define SLFS_DEFS_SVH

`define SLFS_CLK_PERIOD_NS      4
// ------------------------------------------------------------
// Blanking times (ns) and cycle counts (least time, rounded up)
// ------------------------------------------------------------
`define SLFS_T_SUPPLY_NS        1000
`define SLFS_T_OVERCURRENT_LEVEL_ONE_NS          250
`define SLFS_T_OVERCURRENT_LEVEL_TWO_NS          150
`define SLFS_T_SEC_OVP_NS       100000
`define SLFS_T_OTP_NS           18000
`define SLFS_T_FB_OVP_NS        20000
`define SLFS_T_LINE_NS          2000000
`define SLFS_CYC(t)             (((t) + `SLFS_CLK_PERIOD_NS - 1) / `SLFS_CLK_PERIOD_NS)
`define SLFS_N_SUPPLY           `SLFS_CYC(`SLFS_T_SUPPLY_NS)
`define SLFS_N_OVERCURRENT_LEVEL_ONE             `SLFS_CYC(`SLFS_T_OVERCURRENT_LEVEL_ONE_NS)
`define SLFS_N_OVERCURRENT_LEVEL_TWO             `SLFS_CYC(`SLFS_T_OVERCURRENT_LEVEL_TWO_NS)
`define SLFS_N_SEC_OVP          `SLFS_CYC(`SLFS_T_SEC_OVP_NS)
`define SLFS_N_OTP              `SLFS_CYC(`SLFS_T_OTP_NS)
`define SLFS_N_FB_OVP           `SLFS_CYC(`SLFS_T_FB_OVP_NS)
`define SLFS_N_LINE             `SLFS_CYC(`SLFS_T_LINE_NS)
// Restart delays (cycles), defaults only; real values set externally
`define SLFS_N_RESTART          1000000
`define SLFS_N_RESTART_FAST     100000
`define SLFS_CNT_W              24

`endif

// [slfs_pkg.sv]
// Types for the supply lockout and fault supervisor.
// Assumes slfs_defs.svh is on the include path.
package slfs_pkg;
    typedef enum logic [2:0] {
        SLFS_RESET   = 3'b000,
        SLFS_MONITOR = 3'b001,
        SLFS_SOFT    = 3'b010,
        SLFS_RUN     = 3'b011,
        SLFS_RESTART = 3'b100
    } slfs_state_t;
endpackage

// [slfs_supervisor.sv]
// Supply lockout and fault supervisor of a flyback controller.
// Assumes all comparator inputs are synchronous to sys_clk.
`timescale 1ns/1ps
`include "slfs_defs.svh"

// Summary of operation
// - Lockout hysteresis: enable above turn-on, reset below disable threshold after 1 us.
// - After enable, start switching only when no fault is flagged.
// - Clamp sink enabled only in start-up, restart and burst pause.
// - Supply overvoltage and input short, 1 us blanking, cause auto-restart.
// - Supply at wake threshold forces burst, priority over loop; ends at burst threshold.
// - Start-up control pin low while supply wake is active, released at burst threshold.
// - Overcurrent level one for 250 ns ends the current switching cycle only.
// - Feedback overvoltage for 20 us stops gate until release threshold.
// - Overcurrent two, secondary overvoltage, overtemperature cause auto-restart.
// - Line undervoltage fast restart, line overvoltage normal restart, 2 ms blanking.
// - Monitor, soft-start and run states; protections checked per state.
module slfs_supervisor #(
    parameter int N_LINE         = `SLFS_N_LINE,
    parameter int N_SEC_OVP      = `SLFS_N_SEC_OVP,
    parameter int N_RESTART      = `SLFS_N_RESTART,
    parameter int N_RESTART_FAST = `SLFS_N_RESTART_FAST,
    parameter bit BURST_EN       = 1'b1
) (
    input  wire logic                 sys_clk,
    input  wire logic                 arst_n,
    input  wire logic                 supply_above_turn_on,
    input  wire logic                 supply_below_disable,
    input  wire logic                 supply_below_wake,
    input  wire logic                 supply_above_burst,
    input  wire logic                 supply_above_overvoltage,
    input  wire logic                 input_below_short,
    input  wire logic                 input_below_brown_in,
    input  wire logic                 input_above_overvoltage,
    input  wire logic                 ocp_level_one,
    input  wire logic                 ocp_level_two,
    input  wire logic                 secondary_ovp,
    input  wire logic                 overtemperature,
    input  wire logic                 feedback_ov_trip,
    input  wire logic                 feedback_ov_release,
    input  wire logic                 softstart_done,
    input  wire logic                 loop_burst_pause,
    input  wire logic                 cycle_start,
    output slfs_pkg::slfs_state_t     state,
    output logic                      gate_enable,
    output logic                      burst_active,
    output logic                      clamp_sink_en,
    output logic                      startup_control_pin_n,
    output logic                      restart_pending
);
    import slfs_pkg::*;

    // ------------------------------------------------------------
    // Blanking qualifiers
    // ------------------------------------------------------------
    slfs_state_t             state_r;
    slfs_state_t             state_nxt;
    logic in_mon;
    logic in_active;
    logic in_any;
    logic [8:0] cmp_v;
    logic [8:0] en_v;
    logic [8:0] flt_v;

    assign in_mon    = (state_r == SLFS_MONITOR);
    assign in_active = (state_r == SLFS_SOFT) || (state_r == SLFS_RUN);
    assign in_any    = in_mon || in_active;

    assign cmp_v = {feedback_ov_trip, overtemperature, secondary_ovp, ocp_level_two, ocp_level_one,
                    input_above_overvoltage, input_below_brown_in, input_below_short,
                    supply_above_overvoltage};
    assign en_v  = {in_active, in_any, in_active, in_active, in_active,
                    in_any, in_any, in_any, in_active};

    // Any enabled comparator high keeps monitor from starting soft-start
    logic mon_busy;
    assign mon_busy = |(cmp_v & en_v);

    localparam int BLANK_N [9] = '{`SLFS_N_SUPPLY, `SLFS_N_SUPPLY, N_LINE, N_LINE, `SLFS_N_OVERCURRENT_LEVEL_ONE,
                                   `SLFS_N_OVERCURRENT_LEVEL_TWO, N_SEC_OVP, `SLFS_N_OTP, `SLFS_N_FB_OVP};

    generate
        for (genvar i = 0; i < 9; i++) begin : g_blank
            slfs_blank #(.N(BLANK_N[i])) u_blank (
                .sys_clk (sys_clk),
                .arst_n  (arst_n),
                .en      (en_v[i]),
                .cmp     (cmp_v[i]),
                .fault   (flt_v[i])
            );
        end
    endgenerate

    // Supply disable filter, active in every state
    logic uv_fault;
    slfs_blank #(.N(`SLFS_N_SUPPLY)) u_uv (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .en      (1'b1),
        .cmp     (supply_below_disable),
        .fault   (uv_fault)
    );

    logic restart_fault;
    logic fast_fault;
    assign fast_fault    = flt_v[2];
    assign restart_fault = flt_v[0] | flt_v[1] | flt_v[3] | flt_v[5] | flt_v[6] | flt_v[7];

    // ------------------------------------------------------------
    // State machine and restart timer
    // ------------------------------------------------------------
    logic [`SLFS_CNT_W-1:0] rst_cnt_r;
    logic [`SLFS_CNT_W-1:0] rst_cnt_nxt;
    logic                   fb_hold_r;
    logic                   fb_hold_nxt;
    logic                   ocp_cut_r;
    logic                   ocp_cut_nxt;
    logic                   wake_r;
    logic                   wake_nxt;

    always_comb begin
        state_nxt   = state_r;
        rst_cnt_nxt = rst_cnt_r;
        fb_hold_nxt = fb_hold_r;
        ocp_cut_nxt = ocp_cut_r;
        wake_nxt    = wake_r;
        // Feedback overvoltage latch, cleared only below release
        if (flt_v[8]) begin
            fb_hold_nxt = 1'b1;
        end else if (feedback_ov_release) begin
            fb_hold_nxt = 1'b0;
        end
        // Level-one cut lasts to the next switching cycle
        if (flt_v[4]) begin
            ocp_cut_nxt = 1'b1;
        end else if (cycle_start) begin
            ocp_cut_nxt = 1'b0;
        end
        if (BURST_EN && supply_below_wake && in_active) begin
            wake_nxt = 1'b1;
        end else if (supply_above_burst || !in_active) begin
            wake_nxt = 1'b0;
        end
        unique case (state_r)
            SLFS_RESET: begin
                if (supply_above_turn_on) begin
                    state_nxt = SLFS_MONITOR;
                end
            end
            SLFS_MONITOR, SLFS_SOFT, SLFS_RUN: begin
                if (fast_fault || restart_fault) begin
                    state_nxt   = SLFS_RESTART;
                    rst_cnt_nxt = fast_fault ? N_RESTART_FAST[`SLFS_CNT_W-1:0]
                                             : N_RESTART[`SLFS_CNT_W-1:0];
                end else if (state_r == SLFS_MONITOR && !fb_hold_r && !mon_busy) begin
                    state_nxt = SLFS_SOFT;
                end else if (state_r == SLFS_SOFT && softstart_done) begin
                    state_nxt = SLFS_RUN;
                end
            end
            SLFS_RESTART: begin
                if (rst_cnt_r == '0) begin
                    state_nxt = SLFS_MONITOR;
                end else begin
                    rst_cnt_nxt = rst_cnt_r - 1'b1;
                end
            end
            default: state_nxt = SLFS_RESET;
        endcase
        // Lockout wins from any state
        if (uv_fault) begin
            state_nxt   = SLFS_RESET;
            rst_cnt_nxt = '0;
            wake_nxt    = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r   <= SLFS_RESET;
            rst_cnt_r <= '0;
            fb_hold_r <= 1'b0;
            ocp_cut_r <= 1'b0;
            wake_r    <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            fb_hold_r <= fb_hold_nxt;
            ocp_cut_r <= ocp_cut_nxt;
            wake_r    <= wake_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign state                 = state_r;
    assign burst_active          = wake_r || (in_active && loop_burst_pause);
    // Gate blocked outside soft/run, during feedback hold and cut cycle
    assign gate_enable           = in_active && !fb_hold_r && !ocp_cut_r && !flt_v[4];
    assign clamp_sink_en         = (state_r == SLFS_MONITOR) || (state_r == SLFS_SOFT) ||
                                   (state_r == SLFS_RESTART) || burst_active;
    assign startup_control_pin_n = !wake_r;
    assign restart_pending       = (state_r == SLFS_RESTART);

    a_uv_reset: assert property (@(posedge sys_clk) disable iff (!arst_n)
        uv_fault |=> state_r == SLFS_RESET) else $error("lockout did not reset");
    a_no_switch_fault: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_r == SLFS_MONITOR && fb_hold_r) |=> state_r != SLFS_SOFT) else $error("start with fault");
    a_mon_fault: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_r == SLFS_MONITOR && mon_busy) |=> state_r != SLFS_SOFT) else $error("start with comparator high");
    a_clamp_run: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_r == SLFS_RUN && !burst_active) |-> !clamp_sink_en) else $error("clamp in run");
    a_restart_entry: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (in_any && restart_fault && !uv_fault) |=> state_r == SLFS_RESTART) else $error("no restart");
    a_wake_burst: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wake_r |-> burst_active) else $error("wake without burst");
    a_startup_pin: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (wake_r && supply_above_burst && !supply_below_wake) |=> startup_control_pin_n) else $error("pin held");
    a_overcurrent_level_one_cut: assert property (@(posedge sys_clk) disable iff (!arst_n)
        flt_v[4] |=> !gate_enable) else $error("gate not cut");
    a_fb_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (fb_hold_r && !feedback_ov_release) |=> !gate_enable) else $error("gate during fb hold");
    a_restart_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_r == SLFS_RESTART) |-> !gate_enable) else $error("gate in restart");
    a_fast_load: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (in_any && fast_fault && !uv_fault) |=> rst_cnt_r == N_RESTART_FAST[`SLFS_CNT_W-1:0])
        else $error("fast delay wrong");
endmodule // slfs_supervisor

// [testbench.sv]
// Self-checking bench for the supply lockout and fault supervisor.
// Assumes slfs_pkg is compiled and short restart delays are set here.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module testbench;
    import slfs_pkg::*;
    logic        sys_clk, arst_n;
    int          vcc_mv;
    logic [6:1]  flt;
    logic        overcurrent_level_one, fb_trip, fb_rel, ss_done, cyc, lbp;
    logic        a_on, b_min, b_wake, a_burst, a_max;
    slfs_state_t state;
    logic        gate_enable, burst_active, clamp_sink_en, startup_control_pin_n, restart_pending;
    int          check_count = 0;
    int          bad_count = 0;
    int          nb[7] = '{250, 250, 38, 20, 4500, 20, 20};
    int          rl[7] = '{50, 50, 50, 50, 50, 10, 50};

    slfs_analog_model i_slfs_analog_model (.vcc_mv(vcc_mv), .above_on(a_on), .below_min(b_min),
        .below_wake(b_wake), .above_burst(a_burst), .above_max(a_max));
    slfs_supervisor #(.N_LINE(20), .N_SEC_OVP(20), .N_RESTART(50), .N_RESTART_FAST(10)) i_slfs_supervisor (
        .sys_clk(sys_clk), .arst_n(arst_n), .supply_above_turn_on(a_on), .supply_below_disable(b_min),
        .supply_below_wake(b_wake), .supply_above_burst(a_burst), .supply_above_overvoltage(a_max),
        .input_below_short(flt[1]), .ocp_level_two(flt[2]), .secondary_ovp(flt[3]),
        .overtemperature(flt[4]), .input_below_brown_in(flt[5]), .input_above_overvoltage(flt[6]),
        .ocp_level_one(overcurrent_level_one), .feedback_ov_trip(fb_trip), .feedback_ov_release(fb_rel),
        .softstart_done(ss_done), .loop_burst_pause(lbp), .cycle_start(cyc), .state(state),
        .gate_enable(gate_enable), .burst_active(burst_active), .clamp_sink_en(clamp_sink_en),
        .startup_control_pin_n(startup_control_pin_n), .restart_pending(restart_pending));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wait_st(input slfs_state_t s, input int lim, output int k);
        k = 0;
        while (state !== s && k < lim) begin
            tick(1);
            k++;
        end
    endtask
    task automatic set_f(input int i, input logic v);
        if (i == 0) vcc_mv = v ? 26000 : 15000;
        else flt[i] = v;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_start;
        int k;
        `CHK("state in reset", SLFS_RESET, state)
        `CHK("pin in reset", 1'b1, startup_control_pin_n)
        arst_n = 1'b1;
        tick(10);
        `CHK("below turn-on", SLFS_RESET, state)
        vcc_mv = 15000;
        wait_st(SLFS_SOFT, 10, k);
        `CHK("soft reached", 1'b1, k >= 2 && k <= 3)
        `CHK("gate soft", 1'b1, gate_enable)
        `CHK("clamp soft", 1'b1, clamp_sink_en)
        ss_done = 1'b1;
        tick(2);
        `CHK("run", SLFS_RUN, state)
        `CHK("clamp run", 1'b0, clamp_sink_en)
    endtask
    task automatic t_faults;
        int k;
        for (int i = 0; i < 7; i++) begin
            wait_st(SLFS_RUN, 200, k);
            set_f(i, 1'b1);
            tick(nb[i] - 1);
            set_f(i, 1'b0);
            tick(3);
            `CHK("short fault", SLFS_RUN, state)
            set_f(i, 1'b1);
            wait_st(SLFS_RESTART, nb[i] + 9, k);
            `CHK("blanking", 1'b1, k >= nb[i] && k <= nb[i] + 2)
            set_f(i, 1'b0);
            `CHK("gate restart", 1'b0, gate_enable)
            `CHK("pending", 1'b1, restart_pending)
            `CHK("clamp restart", 1'b1, clamp_sink_en)
            wait_st(SLFS_MONITOR, 100, k);
            `CHK("restart delay", 1'b1, k >= rl[i] && k <= rl[i] + 2)
        end
    endtask
    task automatic t_gate;
        int k;
        wait_st(SLFS_RUN, 200, k);
        overcurrent_level_one = 1'b1;
        tick(70);
        `CHK("overcurrent_level_one cut", 1'b0, gate_enable)
        `CHK("overcurrent_level_one no restart", SLFS_RUN, state)
        overcurrent_level_one = 1'b0;
        tick(2);
        `CHK("overcurrent_level_one held", 1'b0, gate_enable)
        cyc = 1'b1;
        tick(1);
        cyc = 1'b0;
        tick(2);
        `CHK("overcurrent_level_one resume", 1'b1, gate_enable)
        fb_trip = 1'b1;
        fb_rel = 1'b0;
        tick(5010);
        fb_trip = 1'b0;
        tick(3);
        `CHK("fb hold", 1'b0, gate_enable)
        fb_rel = 1'b1;
        tick(3);
        `CHK("fb resume", 1'b1, gate_enable)
    endtask
    task automatic t_burst;
        lbp = 1'b1;
        tick(1);
        `CHK("loop burst", 1'b1, burst_active)
        `CHK("clamp loop pause", 1'b1, clamp_sink_en)
        lbp = 1'b0;
        tick(1);
        `CHK("loop burst off", 1'b0, burst_active)
        vcc_mv = 7500;
        tick(3);
        `CHK("burst on", 1'b1, burst_active)
        `CHK("pin low", 1'b0, startup_control_pin_n)
        `CHK("clamp burst", 1'b1, clamp_sink_en)
        vcc_mv = 7900;
        tick(3);
        `CHK("burst held", 1'b1, burst_active)
        vcc_mv = 8200;
        tick(3);
        `CHK("burst off", 1'b0, burst_active)
        `CHK("pin release", 1'b1, startup_control_pin_n)
        vcc_mv = 6000;
        tick(256);
        `CHK("lockout", SLFS_RESET, state)
        `CHK("gate lockout", 1'b0, gate_enable)
        flt[5] = 1'b1;
        vcc_mv = 15000;
        tick(5);
        `CHK("held in monitor", SLFS_MONITOR, state)
        `CHK("gate held", 1'b0, gate_enable)
        flt[5] = 1'b0;
        tick(1);
        `CHK("soft after clear", SLFS_SOFT, state)
    endtask

    // ------------------------------------------------------------
    // Clock, main sequence, watchdog
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        arst_n = 1'b0;
        vcc_mv = 10000;
        flt = '0;
        overcurrent_level_one = 1'b0;
        fb_trip = 1'b0;
        fb_rel = 1'b1;
        ss_done = 1'b0;
        cyc = 1'b0;
        lbp = 1'b0;
        tick(6);
        t_start();
        t_faults();
        t_gate();
        t_burst();
        test_done();
    end
    // Runs near 16k cycles; about six times that is a hang
    initial begin
        #400000;
        bad_count++;
        test_done();
    end
endmodule // testbench
